/* File: drive_ctrl_pkg.sv */
// Constants, types and decode helpers for the drive control code monitor
package drive_ctrl_pkg;
  // Clock rate
  localparam int unsigned CLK_MHZ = 40;
  // Times as specified, in their own units
  localparam int unsigned DESKEW_NS = 1000;
  localparam int unsigned PFW_DETECT_US = 2000;
  localparam int unsigned SAMPLE_MAX_US = 500;
  localparam int unsigned STABLE_US = 400;
  localparam int unsigned PFW_WAIT_MS = 1000;
  localparam int unsigned HOLDOFF_MS = 250;
  // Cycle counts derived from the clock rate
  localparam int unsigned DESKEW_CYC = (DESKEW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STABLE_CYC = STABLE_US * CLK_MHZ;
  localparam int unsigned PFW_WAIT_CYC = PFW_WAIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned HOLDOFF_CYC = HOLDOFF_MS * 1000 * CLK_MHZ;
  // Counter widths
  localparam int unsigned DSK_W = 6;
  localparam int unsigned STAB_W = 14;
  localparam int unsigned LONG_W = 26;
  // Control code values
  localparam logic [2:0] CODE_PFW = 3'h0;
  localparam logic [2:0] CODE_UNDRIVEN = 3'h7;
  localparam logic [2:0] CODE_RATE_MIN = 3'h4;
  localparam logic [2:0] SEQ_LAST = 3'h6;
  localparam logic [2:0] SEQ_FIRST = 3'h0;

  typedef enum logic [1:0] {
    PFW_IDLE = 2'b00,
    PFW_DESKEW = 2'b01,
    PFW_ACTIVE = 2'b10,
    PFW_WAIT = 2'b11
  } pfw_state_t;

  // Failure conditions that force the loop bypass
  typedef struct packed {
    logic wrap_fail;
    logic rx_clk_lost;
    logic tx_clk_lost;
    logic hw_error;
  } fault_t;

  // Complete state of the monitor
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] code;
    logic [STAB_W-1:0] stab;
    logic accepted;
    logic [2:0] idx;
    pfw_state_t pfw_state;
    logic [DSK_W-1:0] dsk_cnt;
    logic [LONG_W-1:0] pfw_cnt;
    logic pfw_valid;
    logic [1:0] pdis;
    logic flush_req;
    logic halt;
    logic reset_pulse;
    logic holdoff;
    logic [LONG_W-1:0] hold_cnt;
    logic [1:0] byp_n;
    logic rx_en;
  } state_t;

  // Expected code at each step of the hard reset sequence
  function automatic logic [2:0] hr_seq_value(input logic [2:0] idx);
    logic [2:0] v;
    v = 3'h5;
    unique case (idx)
      3'h0: v = 3'h5;
      3'h1: v = 3'h1;
      3'h2: v = 3'h3;
      3'h3: v = 3'h2;
      3'h4: v = 3'h3;
      3'h5: v = 3'h1;
      3'h6: v = 3'h5;
      default: v = 3'h5;
    endcase
    return v;
  endfunction
endpackage

/* File: drive_control_code_monitor.sv */
// Device control code monitor: warning, hard reset and loop bypass control
`timescale 1ns/1ps
// Function
// RL1: Code zero means power fail warning
// RL2: Codes 7-4 link rate, 3-1 reserved/reset
// RL3: Undriven code lines read as all ones
// RL4: Notice warning code within 2 ms
// RL5: Deskew warning code at least 1 us
// RL6: Stop both ports at frame boundaries
// RL7: Flush cache, then halt writes at block
// RL8: After code change, wait 1 s, reset
// RL9: Reset sequence is 5,1,3,2,3,1,5
// RL10: Backplane holds each value 1 ms
// RL11: Backplane inserts 4 before leading 5
// RL12: Ignore transient 4 before sequence
// RL13: Sample the code at least every 500 us
// RL14: Accept step if expected, stable 400 us
// RL15: Reset immediately on validated final 5
// RL16: Power-on reset, ready within 1 s
// RL17: Wait 250 ms before sampling again; code holds off only warning entry and only after a sequence reset, still tracks reset sequences
// RL18: New sequence during reset restarts it
// RL19: Non-sequence values use other code functions
// RL20: Two active-low bypass requests, one per channel
// RL21: Bypass held until init and config met
// RL22: Bypass on failure or bypass primitive
// RL23: Keep receiving while bypassed
// RL24: Release on enable primitive, self-test, no fault
// RL25: Bypass on wrap, clock loss, hardware error
// RL26: Synchronise code inputs before any checks
module drive_control_code_monitor #(
  parameter int unsigned STABLE_CYC = drive_ctrl_pkg::STABLE_CYC,
  parameter int unsigned PFW_WAIT_CYC = drive_ctrl_pkg::PFW_WAIT_CYC,
  parameter int unsigned HOLDOFF_CYC = drive_ctrl_pkg::HOLDOFF_CYC
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [2:0] device_control_code_in,
  input wire logic [1:0] frame_boundary_in,
  input wire logic block_boundary_in,
  input wire logic write_cache_en_in,
  input wire logic flush_done_in,
  input wire logic init_done_in,
  input wire logic config_met_in,
  input wire logic self_test_done_in,
  input wire drive_ctrl_pkg::fault_t faults_in,
  input wire logic [1:0] bypass_prim_in,
  input wire logic [1:0] enable_prim_in,
  output logic [2:0] current_code_out,
  output logic pfw_valid_out,
  output logic [1:0] port_disable_out,
  output logic cache_flush_req_out,
  output logic media_write_halt_out,
  output logic hard_reset_pulse_out,
  output logic sample_holdoff_out,
  output logic bypass_request_ch1_n_out,
  output logic bypass_request_ch2_n_out,
  output logic rx_enable_out
);
  localparam logic [drive_ctrl_pkg::STAB_W-1:0] STAB_END =
    drive_ctrl_pkg::STAB_W'(STABLE_CYC - 1);
  localparam logic [drive_ctrl_pkg::LONG_W-1:0] PFW_END =
    drive_ctrl_pkg::LONG_W'(PFW_WAIT_CYC - 1);
  localparam logic [drive_ctrl_pkg::LONG_W-1:0] HOLD_END =
    drive_ctrl_pkg::LONG_W'(HOLDOFF_CYC - 1);
  localparam logic [drive_ctrl_pkg::DSK_W-1:0] DSK_END =
    drive_ctrl_pkg::DSK_W'(drive_ctrl_pkg::DESKEW_CYC - 1);
  localparam int DSK_DEPTH = drive_ctrl_pkg::DESKEW_CYC;

  drive_ctrl_pkg::state_t st_r;
  drive_ctrl_pkg::state_t st_nxt;
  logic changed;
  logic fire;
  logic fail;

  // Next-state logic for the whole monitor
  always_comb
  begin
    st_nxt = st_r;
    changed = 1'b0;
    fire = 1'b0;
    fail = |faults_in;
    // Three-stage synchroniser on the code pins
    st_nxt.s1 = device_control_code_in; // [RL26]
    st_nxt.s2 = st_r.s1; // [RL26]
    st_nxt.s3 = st_r.s2;
    // New code counts once stages two and three agree
    if (st_r.s2 == st_r.s3 && st_r.s3 != st_r.code)
    begin
      st_nxt.code = st_r.s3; // [RL13]
      changed = 1'b1;
    end
    // Stability timer restarts on every code change
    if (changed)
    begin
      st_nxt.stab = '0;
      st_nxt.accepted = 1'b0;
      // A mismatched value breaks the sequence; 4 never matches
      if (st_r.idx != drive_ctrl_pkg::SEQ_FIRST &&
          st_r.s3 != drive_ctrl_pkg::hr_seq_value(st_r.idx))
      begin
        st_nxt.idx = drive_ctrl_pkg::SEQ_FIRST; // [RL12] [RL19]
      end
    end
    else if (st_r.stab != STAB_END)
    begin
      st_nxt.stab = st_r.stab + 1'b1;
    end
    // Sequence step accepted once stable for the full window
    if (!changed && !st_r.accepted && st_r.stab == STAB_END &&
        st_r.code == drive_ctrl_pkg::hr_seq_value(st_r.idx))
    begin
      st_nxt.accepted = 1'b1; // [RL14] [RL9]
      if (st_r.idx == drive_ctrl_pkg::SEQ_LAST)
      begin
        fire = 1'b1; // [RL15]
        st_nxt.idx = drive_ctrl_pkg::SEQ_FIRST;
      end
      else
      begin
        st_nxt.idx = st_r.idx + 3'h1;
      end
    end
    // Sampling holdoff after a hard reset
    if (st_r.holdoff)
    begin
      st_nxt.hold_cnt = st_r.hold_cnt + 1'b1;
      if (st_r.hold_cnt == HOLD_END)
      begin
        st_nxt.holdoff = 1'b0; // [RL17]
      end
    end
    // Power fail warning sequencing
    st_nxt.reset_pulse = 1'b0;
    unique case (st_r.pfw_state)
      drive_ctrl_pkg::PFW_IDLE:
      begin
        // Entry from any other code; checked every cycle outside the holdoff
        if (!st_r.holdoff && st_r.code == drive_ctrl_pkg::CODE_PFW)
        begin
          st_nxt.pfw_state = drive_ctrl_pkg::PFW_DESKEW; // [RL1] [RL4]
          st_nxt.dsk_cnt = '0;
        end
      end
      drive_ctrl_pkg::PFW_DESKEW:
      begin
        if (st_r.code != drive_ctrl_pkg::CODE_PFW)
        begin
          st_nxt.pfw_state = drive_ctrl_pkg::PFW_IDLE;
        end
        else if (st_r.dsk_cnt == DSK_END)
        begin
          st_nxt.pfw_state = drive_ctrl_pkg::PFW_ACTIVE; // [RL5]
          st_nxt.pfw_valid = 1'b1;
          st_nxt.flush_req = write_cache_en_in; // [RL7]
        end
        else
        begin
          st_nxt.dsk_cnt = st_r.dsk_cnt + 1'b1;
        end
      end
      drive_ctrl_pkg::PFW_ACTIVE:
      begin
        // Each port stops only on its own frame boundary
        st_nxt.pdis = st_r.pdis | frame_boundary_in; // [RL6]
        if (st_r.flush_req && flush_done_in)
        begin
          st_nxt.flush_req = 1'b0;
        end
        // Writes stop on a block boundary once flushing is over
        if (!st_r.flush_req && block_boundary_in)
        begin
          st_nxt.halt = 1'b1; // [RL7]
        end
        if (st_r.code != drive_ctrl_pkg::CODE_PFW &&
            st_r.pdis == 2'h3 && st_r.halt)
        begin
          st_nxt.pfw_state = drive_ctrl_pkg::PFW_WAIT; // [RL8]
          st_nxt.pfw_cnt = '0;
        end
      end
      drive_ctrl_pkg::PFW_WAIT:
      begin
        st_nxt.pfw_cnt = st_r.pfw_cnt + 1'b1;
        if (st_r.pfw_cnt == PFW_END)
        begin
          st_nxt.reset_pulse = 1'b1; // [RL8]
          st_nxt.pfw_state = drive_ctrl_pkg::PFW_IDLE;
          st_nxt.pfw_valid = 1'b0;
          st_nxt.pdis = 2'h0;
          st_nxt.halt = 1'b0;
          st_nxt.flush_req = 1'b0;
        end
      end
    endcase
    // Hard reset request; restarts any reset already under way
    if (fire)
    begin
      st_nxt.reset_pulse = 1'b1; // [RL16] [RL18]
      st_nxt.holdoff = 1'b1; // [RL17]
      st_nxt.hold_cnt = '0;
      st_nxt.pfw_state = drive_ctrl_pkg::PFW_IDLE;
      st_nxt.pfw_valid = 1'b0;
      st_nxt.pdis = 2'h0;
      st_nxt.halt = 1'b0;
      st_nxt.flush_req = 1'b0;
    end
    // Loop bypass request per channel
    for (int ch = 0; ch < 2; ch++)
    begin
      if (fail || bypass_prim_in[ch] || !init_done_in || !config_met_in)
      begin
        st_nxt.byp_n[ch] = 1'b0; // [RL20] [RL21] [RL22] [RL25]
      end
      else if (enable_prim_in[ch] && self_test_done_in)
      begin
        st_nxt.byp_n[ch] = 1'b1; // [RL24]
      end
    end
    // Receiver stays on whether bypassed or not
    st_nxt.rx_en = 1'b1; // [RL23]
  end

  // State register with synchronous reset
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      st_r <= '0;
      st_r.s1 <= drive_ctrl_pkg::CODE_UNDRIVEN; // [RL3]
      st_r.s2 <= drive_ctrl_pkg::CODE_UNDRIVEN;
      st_r.s3 <= drive_ctrl_pkg::CODE_UNDRIVEN;
      st_r.code <= drive_ctrl_pkg::CODE_UNDRIVEN; // [RL3]
      st_r.pfw_state <= drive_ctrl_pkg::PFW_IDLE;
      st_r.rx_en <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign current_code_out = st_r.code; // [RL2]
  assign pfw_valid_out = st_r.pfw_valid;
  assign port_disable_out = st_r.pdis;
  assign cache_flush_req_out = st_r.flush_req;
  assign media_write_halt_out = st_r.halt;
  assign hard_reset_pulse_out = st_r.reset_pulse;
  assign sample_holdoff_out = st_r.holdoff;
  assign bypass_request_ch1_n_out = st_r.byp_n[0];
  assign bypass_request_ch2_n_out = st_r.byp_n[1];
  assign rx_enable_out = st_r.rx_en;

  // Checks on the monitor's own behaviour
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  property p_pfw_deskew;
    $rose(st_r.pfw_valid) |->
      $past(st_r.code == drive_ctrl_pkg::CODE_PFW, DSK_DEPTH);
  endproperty
  a_pfw_deskew: assert property (p_pfw_deskew) // [RL5]
    else $error("warning accepted before deskew");

  property p_port_frame;
    (st_r.pdis & ~$past(st_r.pdis) & ~$past(frame_boundary_in)) == 2'h0;
  endproperty
  a_port_frame: assert property (p_port_frame) // [RL6]
    else $error("port disabled off a frame boundary");

  property p_halt_block;
    $rose(st_r.halt) |-> $past(block_boundary_in && !st_r.flush_req);
  endproperty
  a_halt_block: assert property (p_halt_block) // [RL7]
    else $error("write halt off a block boundary or before flush");

  property p_final_step;
    $rose(st_r.holdoff) |-> st_r.reset_pulse &&
      $past(st_r.idx) == drive_ctrl_pkg::SEQ_LAST &&
      $past(st_r.stab) == STAB_END;
  endproperty
  a_final_step: assert property (p_final_step) // [RL15]
    else $error("hard reset without validated final step");

  property p_step_stable;
    (st_r.idx != $past(st_r.idx)) && (st_r.idx != 3'h0) |->
      $past(st_r.stab) == STAB_END &&
      $past(st_r.code) == drive_ctrl_pkg::hr_seq_value($past(st_r.idx));
  endproperty
  a_step_stable: assert property (p_step_stable) // [RL14]
    else $error("sequence step accepted early or on wrong code");

  property p_holdoff_quiet;
    st_r.holdoff |-> st_r.pfw_state == drive_ctrl_pkg::PFW_IDLE;
  endproperty
  a_holdoff_quiet: assert property (p_holdoff_quiet) // [RL17]
    else $error("code acted upon during holdoff");

  property p_init_bypass;
    !init_done_in |=> st_r.byp_n == 2'h0;
  endproperty
  a_init_bypass: assert property (p_init_bypass) // [RL21]
    else $error("bypass released before init");

  property p_fault_bypass;
    (|faults_in) |=> st_r.byp_n == 2'h0 ##1
      (st_r.byp_n == 2'h0 || !$past(|faults_in));
  endproperty
  a_fault_bypass: assert property (p_fault_bypass) // [RL25]
    else $error("bypass not asserted on failure");

  property p_release;
    $rose(st_r.byp_n[0]) |-> $past(enable_prim_in[0] && self_test_done_in);
  endproperty
  a_release: assert property (p_release) // [RL24]
    else $error("bypass released without enable and self-test");

  property p_code_sync;
    st_r.code != $past(st_r.code) |-> $past(st_r.s2 == st_r.s3);
  endproperty
  a_code_sync: assert property (p_code_sync) // [RL26]
    else $error("code taken before synchroniser agreed");

  property p_rx_on;
    st_r.byp_n != 2'h3 |-> st_r.rx_en;
  endproperty
  a_rx_on: assert property (p_rx_on) // [RL23]
    else $error("receiver off while bypassed");
endmodule

/* File: backplane_model.sv */
// Backplane controller model that drives the device control code lines
`timescale 1ns/1ps
module backplane_model (
  input wire logic clk_sys_in,
  output logic [2:0] device_control_code_out
);
  logic [2:0] drive_low;
  integer seed;

  // Open-drain lines with drive-side pull-ups: released lines read high
  assign device_control_code_out = ~drive_low;

  initial
  begin
    drive_low = 3'h0;
    seed = 61798;
  end

  // Present a value; hold 0 picks a random 1 to 1.5 us (40..60 cycles at 40 MHz)
  task automatic put(input logic [2:0] v, input int hold);
    int n;
    n = (hold > 0) ? hold : 40 + ($unsigned($random(seed)) % 21);
    drive_low = ~v;
    repeat (n) @(negedge clk_sys_in);
  endtask

  // Reset sequence; a wrong third value or short hold makes it invalid
  task automatic hard_reset_seq(input logic [2:0] third, input int hold);
    logic [2:0] seq [7];
    seq = '{3'h5, 3'h1, third, 3'h2, 3'h3, 3'h1, 3'h5};
    if (device_control_code_out === 3'h5)
      put(3'h4, hold);
    foreach (seq[i])
      put(seq[i], hold);
  endtask
endmodule

/* File: drive_control_code_monitor_tb.sv */
// Self-checking testbench for the drive control code monitor
`timescale 1ns/1ps
module drive_control_code_monitor_tb;
  localparam int unsigned STAB = 20;
  localparam int unsigned PWAIT = 50;
  localparam int unsigned HOLD = 1000;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic [2:0] code;
  logic [1:0] frame_b = 2'h0;
  logic block_b = 1'b0;
  logic cache_en = 1'b0;
  logic flush_done = 1'b0;
  logic init_done = 1'b0;
  logic config_met = 1'b0;
  logic self_test = 1'b0;
  drive_ctrl_pkg::fault_t faults = '0;
  logic [1:0] byp_prim = 2'h0;
  logic [1:0] en_prim = 2'h0;
  logic [2:0] cur_code;
  logic pfw_valid, flush_req, halt, pulse, holdoff, byp1, byp2, rx_en;
  logic [1:0] port_dis;
  logic [2:0] flag_vec;
  logic exp_q [$];
  logic exp_hold;
  logic [2:0] byp_exp;
  int failures = 0;
  int samples_checked = 0;

  // Clock at 40 MHz
  always #12.5 clk_sys_in = ~clk_sys_in;

  assign flag_vec = {holdoff, pfw_valid, halt};

  backplane_model backplane_model_inst (
    .clk_sys_in(clk_sys_in),
    .device_control_code_out(code)
  );

  drive_control_code_monitor #(
    .STABLE_CYC(STAB),
    .PFW_WAIT_CYC(PWAIT),
    .HOLDOFF_CYC(HOLD)
  ) drive_control_code_monitor_inst (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .device_control_code_in(code),
    .frame_boundary_in(frame_b),
    .block_boundary_in(block_b),
    .write_cache_en_in(cache_en),
    .flush_done_in(flush_done),
    .init_done_in(init_done),
    .config_met_in(config_met),
    .self_test_done_in(self_test),
    .faults_in(faults),
    .bypass_prim_in(byp_prim),
    .enable_prim_in(en_prim),
    .current_code_out(cur_code),
    .pfw_valid_out(pfw_valid),
    .port_disable_out(port_dis),
    .cache_flush_req_out(flush_req),
    .media_write_halt_out(halt),
    .hard_reset_pulse_out(pulse),
    .sample_holdoff_out(holdoff),
    .bypass_request_ch1_n_out(byp1),
    .bypass_request_ch2_n_out(byp2),
    .rx_enable_out(rx_en)
  );

  // Prints the counts and the verdict, then stops
  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Compares one level result
  task automatic chk(input string name, input logic [2:0] exp,
                     input logic [2:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Bounded wait for a flag to reach a level
  task automatic wait_flag(input int idx, input logic lvl, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      @(negedge clk_sys_in);
      if (flag_vec[idx] === lvl)
        return;
    end
    failures++;
    $display("wrong value flag %0d expected %b seen %b", idx, lvl, ~lvl);
    conclude();
  endtask

  // Each reset pulse takes the oldest expected note off the queue
  always @(negedge clk_sys_in)
    if (pulse === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("unexpected reset pulse", 3'h0, 3'h1);
      else
      begin
        exp_hold = exp_q.pop_front();
        chk("reset holdoff", {2'h0, exp_hold}, {2'h0, holdoff});
      end
    end

  initial
  begin
    repeat (2) @(negedge clk_sys_in);
    srst_in = 1'b0;
    chk("bypass at reset", 3'h0, {1'b0, byp2, byp1});
    repeat (5) @(negedge clk_sys_in);
    chk("undriven code", 3'h7, cur_code);
    // Bypass release needs init, config and self-test
    en_prim = 2'h3;
    repeat (3) @(negedge clk_sys_in);
    chk("bypass before init", 3'h0, {1'b0, byp2, byp1});
    chk("rx while bypassed", 3'h1, {2'h0, rx_en});
    init_done = 1'b1;
    config_met = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk("bypass no self-test", 3'h0, {1'b0, byp2, byp1});
    self_test = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk("bypass released", 3'h3, {1'b0, byp2, byp1});
    // Each fault and each channel's bypass primitive
    for (int i = 0; i < 6; i++)
    begin
      en_prim = 2'h0;
      {faults, byp_prim} = 6'h01 << i;
      repeat (2) @(negedge clk_sys_in);
      byp_exp = (i > 1) ? 3'h0 : 3'(2 - i);
      chk("bypass cause", byp_exp, {1'b0, byp2, byp1});
      {faults, byp_prim} = 6'h00;
      en_prim = 2'h3;
      repeat (2) @(negedge clk_sys_in);
    end
    // Valid sequence from code 5, then a restart during the holdoff
    backplane_model_inst.put(3'h5, 60);
    chk("rate code", 3'h5, cur_code);
    exp_q.push_back(1'b1);
    backplane_model_inst.hard_reset_seq(3'h3, 0);
    chk("pending pulses", 3'h0, 3'(exp_q.size()));
    exp_q.push_back(1'b1);
    backplane_model_inst.hard_reset_seq(3'h3, 0);
    chk("restart pulses", 3'h0, 3'(exp_q.size()));
    // Wrong order and too-short holds produce no reset
    backplane_model_inst.hard_reset_seq(3'h2, 0);
    backplane_model_inst.hard_reset_seq(3'h3, 10);
    wait_flag(2, 1'b0, HOLD + 100);
    // Short warning code is refused by the deskew
    backplane_model_inst.put(3'h0, 20);
    backplane_model_inst.put(3'h7, 20);
    chk("short warning", 3'h0, {2'h0, pfw_valid});
    cache_en = 1'b1;
    backplane_model_inst.put(3'h0, 30);
    chk("warning in deskew", 3'h0, {2'h0, pfw_valid});
    wait_flag(1, 1'b1, 30);
    frame_b = 2'h1;
    repeat (2) @(negedge clk_sys_in);
    chk("port 1 stop", 3'h1, {1'b0, port_dis});
    frame_b = 2'h2;
    block_b = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk("ports stopped", 3'h3, {1'b0, port_dis});
    chk("flush request", 3'h1, {2'h0, flush_req});
    chk("halt before flush", 3'h0, {2'h0, halt});
    flush_done = 1'b1;
    wait_flag(0, 1'b1, 10);
    chk("flush cleared", 3'h0, {2'h0, flush_req});
    // Code leaves the warning: reset after the wait, without holdoff
    exp_q.push_back(1'b0);
    backplane_model_inst.put(3'h7, 1);
    wait_flag(1, 1'b0, PWAIT + 30);
    repeat (2) @(negedge clk_sys_in);
    chk("warning reset", 3'h0, 3'(exp_q.size()));
    // Second warning with caching off: no flush, halt on block boundary
    cache_en = 1'b0;
    frame_b = 2'h3;
    backplane_model_inst.put(3'h0, 60);
    chk("warning no cache", 3'h1, {2'h0, pfw_valid});
    chk("no flush request", 3'h0, {2'h0, flush_req});
    chk("halt no cache", 3'h1, {2'h0, halt});
    chk("both ports stop", 3'h3, {1'b0, port_dis});
    conclude();
  end
endmodule
